// *** bench/dspwm_load.sv ***
// load model at a timer pin: pulled low, counts high cycles and rising edges
`timescale 1ns/1ps
module dspwm_load (
  // clock and window clear
  input wire logic hclk,
  input wire logic clr,
  // driver side of the pin
  input wire logic lvl,
  input wire logic oe,
  // pin level and figures
  output logic pin,
  output logic [31:0] hi_cnt,
  output logic [31:0] rises
);
  logic last;
  // ==========================================================================
  // a released pin is pulled down, so a stale driver level never shows
  assign pin = oe ? lvl : 1'b0;
  // waveforms are periodic, so a window of whole periods gives fixed figures at any phase
  always @(posedge hclk) begin
    if (clr) begin
      hi_cnt <= 32'h0;
      rises <= 32'h0;
    end else begin
      hi_cnt <= hi_cnt + {31'h0, pin};
      rises <= rises + {31'h0, pin & !last};
    end
    last <= pin;
  end
endmodule

// *** bench/dspwm_properties.sv ***
// checker of bus timing and pin behaviour of the dual-slope pwm timer
`timescale 1ns/1ps
module dspwm_properties
  import dspwm_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave side
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // channel pins
  input wire logic wave_out_a,
  input wire logic wave_out_a_oe,
  input wire logic wave_out_b,
  input wire logic wave_out_b_oe
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take, rd_take, ctrl_wr, con_a, con_b, dual;
  logic [31:0] ctrl;
  logic [3:0] stop_cnt;
  // ==========================================================================
  // shadow of the control register, built only from completed bus writes
  assign take = hsel && hready && htrans[1];
  assign rd_take = take && !hwrite;
  // the pins only take the waveform in one of the dual-slope modes
  assign dual = ctrl[3:0] inside {DSPWM_MODE_PC8, DSPWM_MODE_PC9, DSPWM_MODE_PC10, DSPWM_MODE_PC_CAP,
    DSPWM_MODE_PC_A, DSPWM_MODE_PFC_CAP, DSPWM_MODE_PFC_A};
  assign con_a = dual && ctrl[12] &&
    (ctrl[5] || (ctrl[4] && (ctrl[3:0] == DSPWM_MODE_PFC_A || ctrl[3:0] == DSPWM_MODE_PC_A)));
  assign con_b = dual && ctrl[13] && ctrl[7];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_wr <= 1'b0;
      ctrl <= 32'h0;
    end else if (hready) begin
      ctrl_wr <= take && hwrite && haddr[7:0] == DSPWM_OFF_CTRL;
      if (ctrl_wr) begin
        ctrl <= hwdata & DSPWM_CTRL_MASK;
      end
    end
  end
  // cycles with the prescaler stopped; a tick already in flight needs a few to drain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_cnt <= 4'h0;
    end else if (ctrl[10:8] != DSPWM_PRESC_STOP) begin
      stop_cnt <= 4'h0;
    end else if (stop_cnt != 4'hF) begin
      stop_cnt <= stop_cnt + 4'h1;
    end
  end
  // ==========================================================================
  // assertions
  oe_a_match_a: assert property (wave_out_a_oe == $past(con_a))
    else $error("pin a enable disagrees with code and direction");
  oe_b_match_a: assert property (wave_out_b_oe == $past(con_b))
    else $error("pin b enable disagrees with code and direction");
  stopped_hold_a: assert property (stop_cnt >= 4'h3 |-> $stable(wave_out_a) && $stable(wave_out_b))
    else $error("waveform moved with the prescaler stopped");
  reset_idle_a: assert property ($rose(hresetn) |-> !(wave_out_a || wave_out_b || wave_out_a_oe || wave_out_b_oe))
    else $error("pins not low after reset");
  read_wait_a: assert property (rd_take |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not two cycles");
  write_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  wait_cause_a: assert property ($fell(hreadyout) |-> $past(rd_take))
    else $error("wait state without a read");
  resp_okay_a: assert property (!hresp)
    else $error("error response seen");
  cover property (rd_take);
  cover property ($rose(wave_out_a) && wave_out_a_oe);
  cover property ($rose(wave_out_b_oe));
  cover property (stop_cnt == 4'hF);
endmodule

bind dspwm_top dspwm_properties chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .wave_out_a(wave_out_a), .wave_out_a_oe(wave_out_a_oe),
  .wave_out_b(wave_out_b), .wave_out_b_oe(wave_out_b_oe));

// *** bench/dspwm_tb_top.sv ***
// testbench of the dual-slope pwm timer: bus tasks and waveform checks
`timescale 1ns/1ps
module dspwm_tb_top;
  import dspwm_pkg::*;
  // ==========================================================================
  // bus, pins and load figures
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic clr = 1'b0;
  logic [31:0] hrdata, hi_a, hi_b, rise_a, rise_b;
  logic hreadyout, hresp, wave_out_a, wave_out_a_oe, wave_out_b, wave_out_b_oe;
  logic [7:0] offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C};
  int n_mismatch = 0;
  int comparisons = 0;
  initial forever #4 hclk = ~hclk;
  dspwm_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .wave_out_a(wave_out_a), .wave_out_a_oe(wave_out_a_oe),
    .wave_out_b(wave_out_b), .wave_out_b_oe(wave_out_b_oe));
  dspwm_load load_a (.hclk(hclk), .clr(clr), .lvl(wave_out_a), .oe(wave_out_a_oe), .pin(),
    .hi_cnt(hi_a), .rises(rise_a));
  dspwm_load load_b (.hclk(hclk), .clr(clr), .lvl(wave_out_b), .oe(wave_out_b_oe), .pin(),
    .hi_cnt(hi_b), .rises(rise_b));
  // ==========================================================================
  // verdict, comparison and bus tasks
  task automatic give_verdict();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask
  // the slave decides its own wait states; a hung bus ends the run
  task automatic wait_ready();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (hreadyout !== 1'b1) begin
      n_mismatch++;
      give_verdict();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= DSPWM_HTRANS_NONSEQ;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] want);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, want);
  endtask
  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask
  // {rising edges, high cycles} at a pin over four counter periods
  function automatic logic [63:0] pin_exp(input logic [1:0] c, input int cm, t, n, input logic tg, on);
    int hi;
    hi = 8 * n * cm;
    if (!on || c == DSPWM_CODE_OFF || (c == DSPWM_CODE_TOGGLE && !tg)) return 64'h0;
    if (c == DSPWM_CODE_TOGGLE) return {32'd2, 32'(4 * n * t)};
    if (c == DSPWM_CODE_INV) hi = 8 * n * t - hi;
    return {((cm == 0 || cm >= t) ? 32'd0 : 32'd4), 32'(hi)};
  endfunction
  // one waveform setup from reset: settle three periods, then measure four
  task automatic run_case(input logic [3:0] m, input logic [15:0] top, ca, cb, input logic [1:0] coa, cob,
    input logic [2:0] ps, input logic [1:0] dir);
    int t, n;
    logic [15:0] ma, mb;
    logic [63:0] ea, eb;
    n = (ps == DSPWM_PRESC_1) ? 1 : (ps == DSPWM_PRESC_8) ? 8 : (ps == DSPWM_PRESC_64) ? 64 :
      (ps == DSPWM_PRESC_256) ? 256 : 1024;
    t = (m == DSPWM_MODE_PC8) ? DSPWM_TOP_8 : (m == DSPWM_MODE_PC9) ? DSPWM_TOP_9 :
      (m == DSPWM_MODE_PC10) ? DSPWM_TOP_10 : (m[0] ? ca : top);
    ma = (m < 4'h8) ? ca & t[15:0] : ca;
    mb = (m < 4'h8) ? cb & t[15:0] : cb;
    do_reset();
    wr(DSPWM_OFF_CAPTOP, {16'h0, top});
    wr(DSPWM_OFF_CMPA, {16'h0, ca});
    wr(DSPWM_OFF_CMPB, {16'h0, cb});
    wr(DSPWM_OFF_CTRL, {28'h0, m});
    // written again under the new mode so that fixed-top masking applies
    wr(DSPWM_OFF_CMPA, {16'h0, ca});
    wr(DSPWM_OFF_CMPB, {16'h0, cb});
    rdc(DSPWM_OFF_CMPA, {16'h0, ma});
    rdc(DSPWM_OFF_CMPB, {16'h0, mb});
    wr(DSPWM_OFF_CTRL, {18'h0, dir, 1'b0, ps, cob, coa, m});
    repeat (6 * n * t) @(posedge hclk);
    wr(DSPWM_OFF_FLAGS, 32'hF);
    clr <= 1'b1;
    @(posedge hclk);
    clr <= 1'b0;
    repeat (8 * n * t) @(posedge hclk);
    #1;
    ea = pin_exp(coa, ma, t, n, m[3] & m[0], dir[0]);
    eb = pin_exp(cob, mb, t, n, 1'b0, dir[1]);
    check(hi_a, ea[31:0]);
    check(rise_a, ea[63:32]);
    check(hi_b, eb[31:0]);
    check(rise_b, eb[63:32]);
    @(posedge hclk);
    rdc(DSPWM_OFF_FLAGS, {28'h0, m == DSPWM_MODE_PFC_CAP || m == DSPWM_MODE_PC_CAP, mb <= t, ma <= t, 1'b1});
    // flags above
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    do_reset();
    for (int k = 0; k < 2; k++) begin
      foreach (offs[i]) begin
        rdc(offs[i], 32'h0);
      end
      wr(DSPWM_OFF_COUNT, 32'hFFFF_FFFF);
      wr(8'h1C, 32'hFFFF_FFFF);
      wr(DSPWM_OFF_CTRL, 32'hFFFF_C000);
    end
    run_case(DSPWM_MODE_PFC_CAP, 16'hA, 16'h3, 16'h7, 2'h2, 2'h3, DSPWM_PRESC_1, 2'h3);
    run_case(DSPWM_MODE_PFC_CAP, 16'hA, 16'h3, 16'hC, 2'h2, 2'h0, DSPWM_PRESC_8, 2'h3);
    run_case(DSPWM_MODE_PFC_A, 16'h0, 16'h6, 16'h0, 2'h1, 2'h2, DSPWM_PRESC_1, 2'h3);
    run_case(DSPWM_MODE_PC_A, 16'h0, 16'h6, 16'h6, 2'h1, 2'h2, DSPWM_PRESC_1, 2'h3);
    run_case(DSPWM_MODE_PC_CAP, 16'h5, 16'h0, 16'h2, 2'h3, 2'h1, DSPWM_PRESC_1, 2'h3);
    run_case(DSPWM_MODE_PC8, 16'h0, 16'h40, 16'h80, 2'h2, 2'h3, DSPWM_PRESC_1, 2'h1);
    run_case(DSPWM_MODE_PC9, 16'h0, 16'h1234, 16'h100, 2'h2, 2'h0, DSPWM_PRESC_1, 2'h3);
    run_case(DSPWM_MODE_PC10, 16'h0, 16'h300, 16'h3FF, 2'h3, 2'h2, DSPWM_PRESC_1, 2'h3);
    run_case(DSPWM_MODE_PFC_A, 16'h0, 16'h3, 16'h1, 2'h1, 2'h2, DSPWM_PRESC_64, 2'h3);
    run_case(DSPWM_MODE_PC_CAP, 16'h3, 16'h1, 16'h2, 2'h2, 2'h3, DSPWM_PRESC_256, 2'h3);
    run_case(DSPWM_MODE_PFC_CAP, 16'h3, 16'h2, 16'h3, 2'h3, 2'h2, DSPWM_PRESC_1024, 2'h2);
    give_verdict();
  end
endmodule

// *** rtl/dspwm_pkg.sv ***
// constants, register map and field layout of the dual-slope pwm timer
// ==========================================================================
// What this block does
// - phase correct: overflow flag at bottom
// - phase correct: compare buffers load at top
// - phase correct: a/capture flag at top update
// - fixed top: mask compare writes to resolution
// - compare above top never matches
// - code 2 non-inverted, code 3 inverted
// - non-inverted clears up, sets down
// - pin driven only when direction selects output
// - non-inverted: bottom gives constant low, top constant high
// - mode 11 code 1 toggles a
// - modes 8 and 9 are frequency correct
// - mode 8 capture top, 9 compare a
// - counter holds top one timer cycle
// - frequency correct: load and overflow at bottom
// - frequency correct: a/capture flag at top
// - compare match sets channel flag
// - mode 9 code 1 toggles a
// - period twice prescale times top
// - phase correct tops for modes 1,2,3,10,11
// - compare a write goes to buffer
// - capture top takes effect at once
package dspwm_pkg;
  // ========================================================================
  // register byte offsets
  localparam logic [7:0] DSPWM_OFF_CTRL = 8'h00;
  localparam logic [7:0] DSPWM_OFF_CMPA = 8'h04;
  localparam logic [7:0] DSPWM_OFF_CMPB = 8'h08;
  localparam logic [7:0] DSPWM_OFF_CAPTOP = 8'h0C;
  localparam logic [7:0] DSPWM_OFF_COUNT = 8'h10;
  localparam logic [7:0] DSPWM_OFF_FLAGS = 8'h14;
  // ========================================================================
  // control register fields
  localparam int DSPWM_CTRL_MODE_LSB = 0;
  localparam int DSPWM_CTRL_CODEA_LSB = 4;
  localparam int DSPWM_CTRL_CODEB_LSB = 6;
  localparam int DSPWM_CTRL_PRESC_LSB = 8;
  localparam int DSPWM_CTRL_DIRA_BIT = 12;
  localparam int DSPWM_CTRL_DIRB_BIT = 13;
  localparam logic [31:0] DSPWM_CTRL_MASK = 32'h0000_37FF;
  localparam logic [31:0] DSPWM_CTRL_RESET = 32'h0000_0000;
  // ========================================================================
  // flag register bits, write one to clear
  localparam int DSPWM_FLAG_OVF = 0;
  localparam int DSPWM_FLAG_CMPA = 1;
  localparam int DSPWM_FLAG_CMPB = 2;
  localparam int DSPWM_FLAG_CAP = 3;
  // ========================================================================
  // waveform modes, fixed tops, channel output codes
  localparam logic [3:0] DSPWM_MODE_PC8 = 4'h1;
  localparam logic [3:0] DSPWM_MODE_PC9 = 4'h2;
  localparam logic [3:0] DSPWM_MODE_PC10 = 4'h3;
  localparam logic [3:0] DSPWM_MODE_PFC_CAP = 4'h8;
  localparam logic [3:0] DSPWM_MODE_PFC_A = 4'h9;
  localparam logic [3:0] DSPWM_MODE_PC_CAP = 4'hA;
  localparam logic [3:0] DSPWM_MODE_PC_A = 4'hB;
  localparam logic [15:0] DSPWM_TOP_8 = 16'h00FF;
  localparam logic [15:0] DSPWM_TOP_9 = 16'h01FF;
  localparam logic [15:0] DSPWM_TOP_10 = 16'h03FF;
  localparam logic [1:0] DSPWM_CODE_OFF = 2'h0;
  localparam logic [1:0] DSPWM_CODE_TOGGLE = 2'h1;
  localparam logic [1:0] DSPWM_CODE_NONINV = 2'h2;
  localparam logic [1:0] DSPWM_CODE_INV = 2'h3;
  // prescale selects: 0 stopped, then divide by 1, 8, 64, 256, 1024
  localparam logic [2:0] DSPWM_PRESC_STOP = 3'h0;
  localparam logic [2:0] DSPWM_PRESC_1 = 3'h1;
  localparam logic [2:0] DSPWM_PRESC_8 = 3'h2;
  localparam logic [2:0] DSPWM_PRESC_64 = 3'h3;
  localparam logic [2:0] DSPWM_PRESC_256 = 3'h4;
  localparam logic [2:0] DSPWM_PRESC_1024 = 3'h5;
  // ahb transfer types
  localparam logic [1:0] DSPWM_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] DSPWM_HTRANS_SEQ = 2'h3;
endpackage

// *** rtl/dspwm_presc.sv ***
// prescaler producing the timer clock enable from the i/o clock
`timescale 1ns/1ps
module dspwm_presc
  import dspwm_pkg::*;
#(
  parameter int DIV_W = 10
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // divider select and enable out
  input wire logic [2:0] presc_sel,
  output logic tick
);
  logic [DIV_W-1:0] div_cnt;
  logic next_tick;

  // ==========================================================================
  // free running divider; stopping it keeps phase steps out of restart
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt <= '0;
    end else if (presc_sel == DSPWM_PRESC_STOP) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // select which divider tap produces the enable
  always_comb begin
    unique case (presc_sel)
      DSPWM_PRESC_1: next_tick = 1'b1;
      DSPWM_PRESC_8: next_tick = &div_cnt[2:0];
      DSPWM_PRESC_64: next_tick = &div_cnt[5:0];
      DSPWM_PRESC_256: next_tick = &div_cnt[7:0];
      DSPWM_PRESC_1024: next_tick = &div_cnt[9:0];
      default: next_tick = 1'b0;
    endcase
  end

  // registered enable, one i/o clock wide
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick <= 1'b0;
    end else begin
      tick <= next_tick;
    end
  end
endmodule

// *** rtl/dspwm_top.sv ***
// dual-slope 16-bit pwm timer with two compare channels and ahb-lite registers
`timescale 1ns/1ps
module dspwm_top
  import dspwm_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // ahb-lite clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave port
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // channel a pin
  output logic wave_out_a,
  output logic wave_out_a_oe,
  // channel b pin
  output logic wave_out_b,
  output logic wave_out_b_oe
);
  // ==========================================================================
  // decoding helpers
  function automatic logic is_pc(input logic [3:0] m);
    is_pc = (m == DSPWM_MODE_PC8) || (m == DSPWM_MODE_PC9) || (m == DSPWM_MODE_PC10) ||
            (m == DSPWM_MODE_PC_CAP) || (m == DSPWM_MODE_PC_A);
  endfunction

  function automatic logic is_pfc(input logic [3:0] m);
    is_pfc = (m == DSPWM_MODE_PFC_CAP) || (m == DSPWM_MODE_PFC_A);
  endfunction

  function automatic logic top_is_a(input logic [3:0] m);
    top_is_a = (m == DSPWM_MODE_PC_A) || (m == DSPWM_MODE_PFC_A);
  endfunction

  function automatic logic top_is_cap(input logic [3:0] m);
    top_is_cap = (m == DSPWM_MODE_PC_CAP) || (m == DSPWM_MODE_PFC_CAP);
  endfunction

  // ==========================================================================
  // declarations
  logic [31:0] ctrl;
  logic [CNT_W-1:0] capture_top_reg;
  logic [CNT_W-1:0] count_value;
  logic count_up;
  logic [3:0] flags;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic rd_pend;
  logic [7:0] rd_addr;
  logic tick;
  logic [3:0] waveform_mode_sel;
  logic [2:0] presc_sel;
  logic [1:0] chan_output_code [2];
  logic [1:0] pin_direction_bit;
  logic dual_mode;
  logic running;
  logic [CNT_W-1:0] top_val;
  logic [CNT_W-1:0] fixed_mask;
  logic fixed_top;
  logic at_top;
  logic at_bottom;
  logic up_phase;
  logic load_now;
  logic [CNT_W-1:0] cmp_buf [2];
  logic [CNT_W-1:0] cmp_act [2];
  logic [1:0] match;
  logic [1:0] wave;
  logic [1:0] connected;
  logic [3:0] flag_set;
  logic [3:0] flag_clr;
  logic [31:0] rd_mux;
  logic addr_ok;

  // ==========================================================================
  // control field extraction
  assign waveform_mode_sel = ctrl[DSPWM_CTRL_MODE_LSB +: 4];
  assign chan_output_code[0] = ctrl[DSPWM_CTRL_CODEA_LSB +: 2];
  assign chan_output_code[1] = ctrl[DSPWM_CTRL_CODEB_LSB +: 2];
  assign presc_sel = ctrl[DSPWM_CTRL_PRESC_LSB +: 3];
  assign pin_direction_bit = {ctrl[DSPWM_CTRL_DIRB_BIT], ctrl[DSPWM_CTRL_DIRA_BIT]};
  assign dual_mode = is_pc(waveform_mode_sel) || is_pfc(waveform_mode_sel);

  // ==========================================================================
  // prescaler
  dspwm_presc #(
    .DIV_W(10)
  ) u_presc (
    .hclk(hclk),
    .hresetn(hresetn),
    .presc_sel(presc_sel),
    .tick(tick)
  );

  // timer logic advances only on enabled cycles of a dual-slope mode
  assign running = dual_mode && tick;

  // ==========================================================================
  // top selection
  always_comb begin
    top_val = {CNT_W{1'b1}};
    fixed_top = 1'b1;
    unique case (waveform_mode_sel)
      DSPWM_MODE_PC8: top_val = DSPWM_TOP_8;
      DSPWM_MODE_PC9: top_val = DSPWM_TOP_9;
      DSPWM_MODE_PC10: top_val = DSPWM_TOP_10;
      default: fixed_top = 1'b0;
    endcase
    // capture top is unbuffered, so a write acts at once
    if (top_is_cap(waveform_mode_sel)) begin
      top_val = capture_top_reg;
    end
    if (top_is_a(waveform_mode_sel)) begin
      top_val = cmp_act[0];
    end
  end

  // bits above the fixed resolution are cleared on compare writes
  assign fixed_mask = fixed_top ? top_val : {CNT_W{1'b1}};

  // ==========================================================================
  // counter turnaround points
  assign at_top = (count_value == top_val);
  assign at_bottom = (count_value == '0);
  // bottom counts as rising, top as falling, which makes the extremes steady;
  // a compare at either end then gives a constant level instead of a glitch
  always_comb begin
    up_phase = count_up;
    if (at_bottom) begin
      up_phase = 1'b1;
    end else if (at_top) begin
      up_phase = 1'b0;
    end
  end

  // compare buffers load at top for phase correct, at bottom for the other
  assign load_now = running && ((is_pc(waveform_mode_sel) && at_top) ||
                                (is_pfc(waveform_mode_sel) && at_bottom));

  // up from zero to top, one cycle at top, then down to zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_value <= '0;
      count_up <= 1'b1;
    end else if (running) begin
      if (count_up) begin
        if (at_top) begin
          count_up <= 1'b0;
          count_value <= count_value - 1'b1;
        end else begin
          count_value <= count_value + 1'b1;
        end
      end else begin
        if (at_bottom) begin
          count_up <= 1'b1;
          count_value <= count_value + 1'b1;
        end else begin
          count_value <= count_value - 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // compare channels
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      logic [CNT_W-1:0] buf_q;
      logic [CNT_W-1:0] act_q;
      logic wave_q;
      logic wr_hit;
      logic is_toggle;

      assign wr_hit = wr_pend && (wr_addr == ((g == 0) ? DSPWM_OFF_CMPA : DSPWM_OFF_CMPB));
      // toggle only exists on channel a with compare a as top
      assign is_toggle = (g == 0) && top_is_a(waveform_mode_sel) &&
                         (chan_output_code[g] == DSPWM_CODE_TOGGLE);

      // software writes land in the buffer only
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          buf_q <= '0;
        end else if (wr_hit) begin
          buf_q <= hwdata[CNT_W-1:0] & fixed_mask;
        end
      end

      // active compare follows the buffer at the update point
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          act_q <= '0;
        end else if (load_now || !dual_mode) begin
          act_q <= buf_q;
        end
      end

      // a compare value above top can never match
      assign match[g] = running && (count_value == act_q) && (act_q <= top_val);

      // waveform register
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          wave_q <= 1'b0;
        end else if (match[g]) begin
          if (is_toggle) begin
            wave_q <= ~wave_q;
          end else if (chan_output_code[g] == DSPWM_CODE_NONINV) begin
            wave_q <= !up_phase;
          end else if (chan_output_code[g] == DSPWM_CODE_INV) begin
            wave_q <= up_phase;
          end
        end
      end

      assign connected[g] = dual_mode && ((chan_output_code[g] == DSPWM_CODE_NONINV) ||
                            (chan_output_code[g] == DSPWM_CODE_INV) || is_toggle);
      assign cmp_buf[g] = buf_q;
      assign cmp_act[g] = act_q;
      assign wave[g] = wave_q;
    end
  endgenerate

  // pin enables; the level itself comes straight from the wave register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wave_out_a_oe <= 1'b0;
      wave_out_b_oe <= 1'b0;
    end else begin
      wave_out_a_oe <= connected[0] && pin_direction_bit[0];
      wave_out_b_oe <= connected[1] && pin_direction_bit[1];
    end
  end

  assign wave_out_a = wave[0];
  assign wave_out_b = wave[1];

  // ==========================================================================
  // event flags
  always_comb begin
    flag_set = '0;
    flag_set[DSPWM_FLAG_OVF] = running && at_bottom;
    flag_set[DSPWM_FLAG_CMPA] = match[0] ||
                                (running && at_top && top_is_a(waveform_mode_sel));
    flag_set[DSPWM_FLAG_CMPB] = match[1];
    flag_set[DSPWM_FLAG_CAP] = running && at_top && top_is_cap(waveform_mode_sel);
  end

  assign flag_clr = (wr_pend && (wr_addr == DSPWM_OFF_FLAGS)) ? hwdata[3:0] : 4'h0;

  // a new event wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end

  // ==========================================================================
  // ahb-lite address phase capture
  // idle and busy transfers are ignored; hsize is not decoded as only words are used
  assign addr_ok = hsel && hready && ((htrans == DSPWM_HTRANS_NONSEQ) || (htrans == DSPWM_HTRANS_SEQ));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else begin
      wr_pend <= addr_ok && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // reads take one wait state so a preceding write is always visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend <= 1'b0;
      rd_addr <= '0;
      hreadyout <= 1'b1;
    end else if (rd_pend) begin
      rd_pend <= 1'b0;
      hreadyout <= 1'b1;
    end else if (addr_ok && !hwrite) begin
      rd_pend <= 1'b1;
      rd_addr <= haddr[7:0];
      hreadyout <= 1'b0;
    end
  end

  // ==========================================================================
  // control and capture registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= DSPWM_CTRL_RESET;
    end else if (wr_pend && (wr_addr == DSPWM_OFF_CTRL)) begin
      ctrl <= hwdata & DSPWM_CTRL_MASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      capture_top_reg <= '0;
    end else if (wr_pend && (wr_addr == DSPWM_OFF_CAPTOP)) begin
      capture_top_reg <= hwdata[CNT_W-1:0];
    end
  end

  // ==========================================================================
  // read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (rd_addr)
      DSPWM_OFF_CTRL: rd_mux = ctrl;
      DSPWM_OFF_CMPA: rd_mux[CNT_W-1:0] = cmp_buf[0];
      DSPWM_OFF_CMPB: rd_mux[CNT_W-1:0] = cmp_buf[1];
      DSPWM_OFF_CAPTOP: rd_mux[CNT_W-1:0] = capture_top_reg;
      DSPWM_OFF_COUNT: rd_mux[CNT_W-1:0] = count_value;
      DSPWM_OFF_FLAGS: rd_mux[3:0] = flags;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // hrdata holds the last read word until the data phase of the next read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0; // every transfer answers okay
      if (rd_pend) begin
        hrdata <= rd_mux;
      end
    end
  end
endmodule
